// *** common/amp_fault_defs.svh ***
`ifndef AMP_FAULT_DEFS_SVH
`define AMP_FAULT_DEFS_SVH

// reference clock
`define REF_CLK_KHZ 40000
`define REF_CLK_PERIOD_NS 25

// switching frame rate and frame length in reference cycles
`define FS_KHZ 400
`define FRAME_CYCLES (`REF_CLK_KHZ / `FS_KHZ)

// persistent current limiting time before the overload latch trips
`define OLP_TIME_US 1700
`define OLP_FRAMES ((`OLP_TIME_US * `FS_KHZ) / 1000)

// output ramp-down after reset falls (least time, rounds up)
`define RAMP_DOWN_US 100
`define RAMP_CYCLES ((`RAMP_DOWN_US * 1000 + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// startup sequence after reset rises (least time, rounds up)
`define STARTUP_US 50
`define STARTUP_CYCLES ((`STARTUP_US * 1000 + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// no sync clock edge for this long counts as stuck (longest time, rounds down)
`define STUCK_US 10
`define STUCK_CYCLES ((`STUCK_US * 1000) / `REF_CLK_PERIOD_NS)

// register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_STATE 4'h2

// control register fields and reset value
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_LATCHED_OC_BIT 2
`define CTRL_SLAVE_BIT 3
`define CTRL_RST 8'h00

// status register fields
`define STAT_OVL_LSB 0
`define STAT_OVL_MSB 3
`define STAT_OTE_BIT 4
`define STAT_UV_BIT 5
`define STAT_STUCK_BIT 6
`define STAT_WARN_BIT 7

`endif

// *** common/amp_fault_pkg.sv ***
package amp_fault_pkg;

    // output stage arrangement of the four half-bridges
    typedef enum logic [1:0] {
        BRIDGED_OUTPUT_MODE,
        PARALLELED_BRIDGE_MODE,
        SINGLE_ENDED_MODE,
        MIXED_MODE
    } out_mode_e;

    // reset / startup sequencer
    typedef enum logic [1:0] {
        ST_RUN,
        ST_RAMP,
        ST_HOLD,
        ST_START
    } seq_state_e;

    // supply monitors, each high while that supply is below its trip point
    typedef struct packed {
        logic power_stage_supply;
        logic main_supply;
        logic analog_supply;
        logic digital_supply;
    } undervoltage_trip_s;

    // detector inputs from the analog front end
    typedef struct packed {
        undervoltage_trip_s uv;
        logic thermal_shutdown;
        logic temp_warning;
        logic [1:0] clip;
        logic [3:0] oc_event;
        logic [3:0] bootstrap_uv;
    } detect_s;

    // per half-bridge drive state
    typedef struct packed {
        logic [3:0] hiz;
        logic [3:0] hs_off;
        logic [3:0] flip;
        logic [3:0] switching;
    } stage_ctrl_s;

endpackage

// *** design/hb_current_limiter.sv ***
`timescale 1ns/1ps

// cycle by cycle limiter and overload counter for one half-bridge
module hb_current_limiter (
    input wire logic clk,
    input wire logic srst,
    input wire logic frame_stb,
    input wire logic third_stb,
    input wire logic oc_event,
    input wire logic latched_mode,
    input wire logic clear,
    input wire logic [15:0] olp_limit,
    output logic flip,
    output logic overload
);
    logic oc_seen_r;   // over-current seen in current frame
    logic limiting_r;  // limiting active from last frame
    logic flip_r;
    logic overload_r;
    logic [15:0] count_r;
    logic oc_frame;
    logic count_full;

    assign oc_frame = oc_seen_r | oc_event;
    assign count_full = (count_r >= olp_limit);
    assign flip = flip_r;
    assign overload = overload_r;

    // frame bookkeeping: the over-current seen flag clears at each frame start
    always_ff @(posedge clk) begin
        if (srst) begin
            oc_seen_r <= 1'b0;
            limiting_r <= 1'b0;
        end else if (frame_stb) begin
            oc_seen_r <= 1'b0;
            limiting_r <= oc_frame;
        end else if (oc_event) begin
            oc_seen_r <= 1'b1;
        end
    end

    // state flip at one third of the switching rate, no reporting
    always_ff @(posedge clk) begin
        if (srst || latched_mode || overload_r) begin
            flip_r <= 1'b0;
        end else if (third_stb && limiting_r) begin
            flip_r <= ~flip_r;
        end else if (frame_stb && !oc_frame) begin
            flip_r <= 1'b0;
        end
    end

    // counter up per over-current frame, down per clean frame
    always_ff @(posedge clk) begin
        if (srst || clear) begin
            count_r <= 16'h0000;
        end else if (frame_stb && oc_frame && !count_full) begin
            count_r <= count_r + 16'h0001;
        end else if (frame_stb && !oc_frame && count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
        end
    end

    // overload latch; a trip in the clearing cycle still sets it
    always_ff @(posedge clk) begin
        if (srst) begin
            overload_r <= 1'b0;
        end else if (count_full || (latched_mode && oc_event)) begin
            overload_r <= 1'b1;
        end else if (clear) begin
            overload_r <= 1'b0;
        end
    end
endmodule

// *** design/amp_fault_top.sv ***
`timescale 1ns/1ps
`include "amp_fault_defs.svh"

module amp_fault_top #(
    parameter int OLP_FRAMES = `OLP_FRAMES
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic RESET_N,
    input wire amp_fault_pkg::detect_s DETECT,
    input wire logic SYNC_CLOCK_PINS,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic FAULT_N,
    output logic CLIP_TEMP_WARNING_N,
    output amp_fault_pkg::stage_ctrl_s STAGE,
    output logic RAMP_ACTIVE,
    output logic PULLDOWN_EN,
    output logic WEAK_PULLDOWN_EN
);
    import amp_fault_pkg::*;

    localparam int FRAME_CYC = `FRAME_CYCLES;
    localparam int RAMP_CYC = `RAMP_CYCLES;
    localparam int START_CYC = `STARTUP_CYCLES;
    localparam int STUCK_CYC = `STUCK_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // register port
    ////////////////////////////////////////////////////////////////////////

    logic [7:0] ctrl_r;         // software control word
    logic [7:0] rdata_r;        // read data, valid one cycle after strobe
    logic [7:0] rd_mux;         // selected register for reads
    logic [7:0] status_word;    // live fault state
    logic [7:0] state_word;     // sequencer and flip state
    out_mode_e out_mode;        // half-bridge arrangement
    logic latched_oc_mode;      // trip on first over-current
    logic slave_mode;           // switching from external sync clock
    logic wr_ctrl;

    assign wr_ctrl = WR && (ADDR == `REG_CTRL);
    assign out_mode = out_mode_e'(ctrl_r[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
    assign latched_oc_mode = ctrl_r[`CTRL_LATCHED_OC_BIT];
    assign slave_mode = ctrl_r[`CTRL_SLAVE_BIT];

    // unmapped offsets read as zero
    assign rd_mux = (ADDR == `REG_CTRL) ? ctrl_r :
                    (ADDR == `REG_STATUS) ? status_word :
                    (ADDR == `REG_STATE) ? state_word : 8'h00;

    // control word write
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ctrl_r <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= WDATA;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge REF_CLK) begin
        if (SRST || !RD) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_mux;
        end
    end

    assign RDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // switching frame divider
    ////////////////////////////////////////////////////////////////////////

    logic [15:0] frame_cnt_r;   // cycles within a frame
    logic [1:0] third_cnt_r;    // frame index modulo three
    logic frame_stb;            // one cycle per switching frame
    logic third_stb;            // one cycle per three frames

    assign frame_stb = (frame_cnt_r == 16'(FRAME_CYC - 1));
    assign third_stb = frame_stb && (third_cnt_r == 2'h2);

    // free running frame counter
    always_ff @(posedge REF_CLK) begin
        if (SRST || frame_stb) begin
            frame_cnt_r <= 16'h0000;
        end else begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
        end
    end

    // divide frames by three for the limiter flip rate
    always_ff @(posedge REF_CLK) begin
        if (SRST || third_stb) begin
            third_cnt_r <= 2'h0;
        end else if (frame_stb) begin
            third_cnt_r <= third_cnt_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync clock activity watchdog
    ////////////////////////////////////////////////////////////////////////

    logic sync_q_r;             // last sampled sync level
    logic [15:0] idle_cnt_r;    // cycles since last sync edge
    logic sync_edge;
    logic stuck;                // no sync activity while slaved

    assign sync_edge = SYNC_CLOCK_PINS ^ sync_q_r;
    assign stuck = slave_mode && (idle_cnt_r >= 16'(STUCK_CYC));

    // either edge restarts the watchdog; saturates when stuck
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sync_q_r <= 1'b0;
            idle_cnt_r <= 16'h0000;
        end else begin
            sync_q_r <= SYNC_CLOCK_PINS;
            if (sync_edge || !slave_mode) begin
                idle_cnt_r <= 16'h0000;
            end else if (idle_cnt_r < 16'(STUCK_CYC)) begin
                idle_cnt_r <= idle_cnt_r + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset pin sequencer
    ////////////////////////////////////////////////////////////////////////

    seq_state_e state_r;
    logic [15:0] timer_r;       // ramp and startup timer
    logic clear_latch;          // one cycle on reset rising; held high for as long as power-on reset lasts
    logic ramp_done;
    logic start_done;

    assign ramp_done = (timer_r == 16'(RAMP_CYC - 1));
    assign start_done = (timer_r == 16'(START_CYC - 1));
    // the rising reset leaves hold; power-on reset also wipes latches
    assign clear_latch = ((state_r == ST_HOLD) && RESET_N) || DETECT.uv.digital_supply;

    // ramp down on reset low, Hi-Z hold, startup on release
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_r <= ST_HOLD;
            timer_r <= 16'h0000;
        end else begin
            timer_r <= timer_r + 16'h0001;
            unique case (state_r)
                ST_RUN: begin
                    timer_r <= 16'h0000;
                    if (!RESET_N) begin
                        state_r <= ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    // finish the ramp before releasing the switches
                    if (ramp_done) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    timer_r <= 16'h0000;
                    if (RESET_N) begin
                        state_r <= ST_START;
                    end
                end
                ST_START: begin
                    if (!RESET_N) begin
                        state_r <= ST_HOLD;
                    end else if (start_done) begin
                        state_r <= ST_RUN;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault sorting
    ////////////////////////////////////////////////////////////////////////

    logic ote_latch_r;          // latched thermal shutdown
    logic [3:0] overload;       // latched overload per half-bridge
    logic [3:0] hb_flip;        // limiter flip per half-bridge
    logic [3:0] chan_off;       // half-bridge belongs to a tripped channel
    logic supply_uv;            // any undervoltage incl. power-on reset
    logic global_hiz;           // all outputs to Hi-Z
    logic reportable;           // drives the fault line

    assign supply_uv = |DETECT.uv;
    // stuck sync is silent, so it only joins the Hi-Z term
    assign global_hiz = supply_uv || ote_latch_r || stuck;
    assign reportable = supply_uv || ((ote_latch_r || (|overload)) && !clear_latch);

    // thermal shutdown holds until the reset pin toggles
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ote_latch_r <= 1'b0;
        end else if (DETECT.thermal_shutdown) begin
            ote_latch_r <= 1'b1;
        end else if (clear_latch) begin
            ote_latch_r <= 1'b0;
        end
    end

    // half-bridges grouped into channels by output mode
    function automatic logic [3:0] channel_of(input out_mode_e mode, input int hb);
        logic [3:0] pair;
        pair = (hb < 2) ? 4'h3 : 4'hc;
        unique case (mode)
            BRIDGED_OUTPUT_MODE: channel_of = pair;
            PARALLELED_BRIDGE_MODE: channel_of = 4'hf;
            SINGLE_ENDED_MODE: channel_of = 4'(1 << hb);
            MIXED_MODE: channel_of = (hb < 2) ? pair : 4'(1 << hb);
        endcase
    endfunction

    // per half-bridge limiter and channel shutdown
    for (genvar i = 0; i < 4; i++) begin : g_hb
        hb_current_limiter u_lim (
            .clk(REF_CLK),
            .srst(SRST),
            .frame_stb(frame_stb),
            .third_stb(third_stb),
            .oc_event(DETECT.oc_event[i] && state_r == ST_RUN && !global_hiz),
            .latched_mode(latched_oc_mode),
            .clear(clear_latch),
            .olp_limit(16'(OLP_FRAMES)),
            .flip(hb_flip[i]),
            .overload(overload[i])
        );
        // only the channel that holds the tripped half-bridge stops
        assign chan_off[i] = |(overload & channel_of(out_mode, i));
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage drive and report lines
    ////////////////////////////////////////////////////////////////////////

    stage_ctrl_s stage_nxt;
    stage_ctrl_s stage_r;
    logic fault_n_r;
    logic warn_n_r;
    logic ramp_r;
    logic pd_r;
    logic weak_pd_r;
    logic switching_ok;         // sequencer allows switching or ramping
    logic reset_low;

    assign reset_low = !RESET_N;
    assign switching_ok = (state_r == ST_RUN) || (state_r == ST_RAMP);

    // Hi-Z on global faults, tripped channel, or outside run and ramp
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            stage_nxt.hiz[i] = global_hiz || chan_off[i] || !switching_ok;
            stage_nxt.switching[i] = !stage_nxt.hiz[i];
            // bootstrap recharge: high side off only, nothing reported
            stage_nxt.hs_off[i] = DETECT.bootstrap_uv[i] && !stage_nxt.hiz[i];
            stage_nxt.flip[i] = hb_flip[i] && !stage_nxt.hiz[i];
        end
    end

    // registered stage outputs
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            stage_r <= '{hiz: 4'hf, hs_off: 4'h0, flip: 4'h0, switching: 4'h0};
            ramp_r <= 1'b0;
        end else begin
            stage_r <= stage_nxt;
            ramp_r <= (state_r == ST_RAMP) && !global_hiz;
        end
    end

    // fault line forced inactive while the reset pin is low
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            fault_n_r <= 1'b1;
        end else begin
            fault_n_r <= reset_low || !reportable;
        end
    end

    // clip and temperature warning share one line; warning needs no action
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            warn_n_r <= 1'b1;
        end else begin
            warn_n_r <= !(DETECT.temp_warning || (|DETECT.clip));
        end
    end

    // pulldowns while reset low; every mode except single-ended, mixed included, gets the weak ones for bootstrap charging
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            pd_r <= 1'b0;
            weak_pd_r <= 1'b0;
        end else begin
            pd_r <= reset_low && (out_mode == SINGLE_ENDED_MODE);
            weak_pd_r <= reset_low && (out_mode != SINGLE_ENDED_MODE);
        end
    end

    assign FAULT_N = fault_n_r;
    assign CLIP_TEMP_WARNING_N = warn_n_r;
    assign STAGE = stage_r;
    assign RAMP_ACTIVE = ramp_r;
    assign PULLDOWN_EN = pd_r;
    assign WEAK_PULLDOWN_EN = weak_pd_r;

    // readable state
    assign status_word = {DETECT.temp_warning, stuck, supply_uv, ote_latch_r, overload};
    assign state_word = {hb_flip, 2'h0, 2'(state_r)};
endmodule

// *** testbench/amp_fault_asserts.sv ***
`timescale 1ns/1ps
`include "amp_fault_defs.svh"
// port-level checker for the fault and reset manager
module amp_fault_asserts #(
    parameter int OLP_FRAMES = 680
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic RESET_N,
    input wire amp_fault_pkg::detect_s DETECT,
    input wire logic SYNC_CLOCK_PINS,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic FAULT_N,
    input wire logic CLIP_TEMP_WARNING_N,
    input wire amp_fault_pkg::stage_ctrl_s STAGE,
    input wire logic RAMP_ACTIVE,
    input wire logic PULLDOWN_EN,
    input wire logic WEAK_PULLDOWN_EN
);
    import amp_fault_pkg::*;
    wire [3:0] uv_w = DETECT.uv; // bit 0 is the digital supply
    logic [15:0] ramp_len_r; // cycles spent in the current ramp
    ////////////////////////////////////////////////////////////////
    // count the ramp length; a reset mid-ramp restarts it
    always_ff @(posedge REF_CLK) begin
        if (SRST || !RAMP_ACTIVE) begin
            ramp_len_r <= 16'h0000;
        end else begin
            ramp_len_r <= ramp_len_r + 16'h0001;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence ramp_go_s;
        $fell(RESET_N) ##0 (STAGE.switching != 4'h0);
    endsequence
    sequence ramp_end_s;
        $fell(RAMP_ACTIVE) ##0 !$past(SRST);
    endsequence
    sequence hot_trip_s;
        DETECT.thermal_shutdown && RESET_N ##1 RESET_N;
    endsequence
    ////////////////////////////////////////////////////////////////
    chk_reset_fault_high: assert property (!RESET_N |=> FAULT_N)
        else $error("fault line low while reset held");
    chk_uv_fault_low: assert property ((RESET_N && |uv_w[3:1]) |=> !FAULT_N)
        else $error("supply undervoltage not reported");
    chk_por_fault_low: assert property ((RESET_N && uv_w[0]) |=> !FAULT_N)
        else $error("power-on reset not reported");
    chk_uv_stage_hiz: assert property (|uv_w |=> STAGE.hiz == 4'hf && STAGE.switching == 4'h0)
        else $error("undervoltage left stages switching");
    chk_warn_line_low: assert property (DETECT.temp_warning |=> !CLIP_TEMP_WARNING_N)
        else $error("warning not shown");
    chk_clip_line_low: assert property (|DETECT.clip |=> !CLIP_TEMP_WARNING_N)
        else $error("clipping not shown");
    chk_warn_line_idle: assert property
        (!DETECT.temp_warning && DETECT.clip == 2'b00 |=> CLIP_TEMP_WARNING_N)
        else $error("warning line low without cause");
    chk_boot_high_off: assert property ((|DETECT.bootstrap_uv && STAGE.switching == 4'hf)
        |=> (STAGE.hs_off & $past(DETECT.bootstrap_uv)) == $past(DETECT.bootstrap_uv))
        else $error("bootstrap undervoltage kept high side on");
    chk_thermal_latch: assert property (hot_trip_s |=> !FAULT_N && STAGE.hiz == 4'hf)
        else $error("thermal shutdown not applied");
    chk_ramp_start: assert property (ramp_go_s |-> ##[1:2] RAMP_ACTIVE)
        else $error("reset fall did not start ramp");
    chk_ramp_length: assert property (ramp_end_s |-> ramp_len_r == `RAMP_CYCLES ##[0:1]
        STAGE.hiz == 4'hf)
        else $error("ramp length or hiz after ramp wrong");
    chk_reset_pulldown: assert property (!RESET_N ##1 !RESET_N |=> PULLDOWN_EN || WEAK_PULLDOWN_EN)
        else $error("no pulldown while reset low");
endmodule

// *** testbench/sys_ctrl_model.sv ***
`timescale 1ns/1ps
// supervising controller: watches fault and warning, drives reset
module sys_ctrl_model #(
    parameter int LOW_CYCLES = 4200,
    parameter int WAIT_CYCLES = 160000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic fault_n,
    input wire logic warn_n,
    input wire logic toggle_req,
    output logic reset_n,
    output logic busy,
    output logic volume_down
);
    logic fault_q; // last fault line level
    int since_fall; // cycles since the fault line fell, saturating
    int low_cnt; // cycles reset has been held low
    initial begin
        reset_n = 1'b1;
        busy = 1'b0;
        volume_down = 1'b0;
    end
    // age of the last fault report
    always @(posedge clk) begin
        fault_q <= fault_n;
        if (srst) begin
            since_fall <= WAIT_CYCLES;
        end else if (fault_q && !fault_n) begin
            since_fall <= 0;
        end else if (since_fall < WAIT_CYCLES) begin
            since_fall <= since_fall + 1;
        end
    end
    // reset cycle: low long enough for the ramp, release only when safe
    always @(posedge clk) begin
        volume_down <= !warn_n;
        if (srst) begin
            reset_n <= 1'b1;
            busy <= 1'b0;
        end else if (toggle_req && !busy) begin
            reset_n <= 1'b0;
            busy <= 1'b1;
            low_cnt <= 0;
        end else if (busy && low_cnt < LOW_CYCLES) begin
            low_cnt <= low_cnt + 1;
        end else if (busy && warn_n && since_fall >= WAIT_CYCLES) begin
            reset_n <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import amp_fault_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    detect_s detect = '0;
    logic sync_pin = 1'b0;
    logic sync_run = 1'b1; // external clock activity on or off
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic toggle = 1'b0;
    logic [7:0] rdata;
    logic fault_n, warn_n, ramp, pd, wpd, reset_n, busy;
    stage_ctrl_s stage;
    int num_errors = 0;
    int checks = 0;
    integer seed = 32'h50e4dff3;
    int hb; // half-bridge under test
    logic saw;
    always #12.5 clk = ~clk;
    // free-running sync clock unless a scenario stops it
    always @(posedge clk) if (sync_run) sync_pin <= ~sync_pin;
    amp_fault_top #(.OLP_FRAMES(8)) i_amp_fault_top (.REF_CLK(clk), .SRST(srst),
        .RESET_N(reset_n), .DETECT(detect), .SYNC_CLOCK_PINS(sync_pin), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FAULT_N(fault_n),
        .CLIP_TEMP_WARNING_N(warn_n), .STAGE(stage), .RAMP_ACTIVE(ramp),
        .PULLDOWN_EN(pd), .WEAK_PULLDOWN_EN(wpd));
    sys_ctrl_model #(.LOW_CYCLES(4200), .WAIT_CYCLES(1000)) i_sys_ctrl_model (.clk(clk),
        .srst(srst), .fault_n(fault_n), .warn_n(warn_n), .toggle_req(toggle),
        .reset_n(reset_n), .busy(busy), .volume_down());
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_vec("register", {8'h00, exp}, {8'h00, rdata});
    endtask
    // bounded wait until every half-bridge switches again
    task automatic wait_run();
        int n;
        n = 0;
        while (stage.switching !== 4'hf && n < 5000) begin
            settle(1);
            n++;
        end
        check_vec("running", 16'h000f, {12'h000, stage.switching});
        if (n >= 5000) close_out();
    endtask
    // one reset cycle through the controller model
    task automatic toggle_reset(input logic se);
        int n;
        @(posedge clk);
        toggle <= 1'b1;
        @(posedge clk);
        toggle <= 1'b0;
        settle(3);
        check_vec("fault forced", 16'h0001, {15'h0, fault_n});
        check_vec("pulldowns", {14'h0, se, !se}, {14'h0, pd, wpd});
        n = 0;
        while (busy && n < 20000) begin
            settle(1);
            n++;
        end
        check_vec("released", 16'h0, {15'h0, busy});
        wait_run();
        reg_read(4'h1, 8'h00);
    endtask
    // half-bridges stopped together with hb in mode m
    function automatic logic [3:0] grp(input int m, input int hb);
        if (m == 1) return 4'hf;
        if (m == 2 || (m == 3 && hb > 1)) return 4'(1 << hb);
        return (hb < 2) ? 4'h3 : 4'hc;
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        wait_run();
        reg_read(4'h0, 8'h00);
        reg_write(4'h1, 8'hff);
        reg_read(4'h1, 8'h00);
        reg_read(4'h2, 8'h00);
        reg_read(4'hf, 8'h00); // unmapped
        // each supply undervoltage, random duration
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            detect.uv <= 4'(1 << i);
            settle(2 + ($random(seed) & 7));
            check_vec("uv report", 16'h00f0, {fault_n, stage.hiz, stage.switching});
            @(posedge clk);
            detect.uv <= 4'h0;
            settle(2);
            check_vec("uv clear", 16'h0001, {15'h0, fault_n});
            wait_run();
        end
        // clip and warning share the line, no fault, still switching
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {detect.temp_warning, detect.clip} <= 3'(1 << i);
            settle(2);
            check_vec("warn", 16'h001f, {warn_n, fault_n, stage.switching});
            @(posedge clk);
            {detect.temp_warning, detect.clip} <= 3'h0;
            settle(2);
            check_vec("warn idle", 16'h0001, {15'h0, warn_n});
        end
        hb = $random(seed) & 3;
        @(posedge clk);
        detect.bootstrap_uv <= 4'(1 << hb);
        settle(2);
        check_vec("bootstrap", 16'h10 | (1 << hb), {fault_n, stage.hs_off});
        @(posedge clk);
        detect.bootstrap_uv <= 4'h0;
        settle(2);
        check_vec("bootstrap clear", 16'h0000, {12'h0, stage.hs_off});
        // latched overcurrent in every output mode
        for (int m = 0; m < 4; m++) begin
            hb = $random(seed) & 3;
            reg_write(4'h0, 8'(4 + m));
            @(posedge clk);
            detect.oc_event[hb] <= 1'b1;
            @(posedge clk);
            detect.oc_event <= 4'h0;
            settle(3);
            check_vec("channel off", {1'b0, grp(m, hb), ~grp(m, hb)},
                {fault_n, stage.hiz, stage.switching});
            toggle_reset(m == 2);
        end
        // persistent cycle limiting flips, then latches the channel off
        reg_write(4'h0, 8'h00);
        hb = $random(seed) & 3;
        saw = 1'b0;
        repeat (14) begin
            @(posedge clk);
            detect.oc_event[hb] <= 1'b1;
            @(posedge clk);
            detect.oc_event <= 4'h0;
            repeat (98) begin
                settle(1);
                saw = saw | stage.flip[hb];
            end
        end
        check_vec("flip seen", 16'h0001, {15'h0, saw});
        check_vec("overload", {1'b0, grp(0, hb), ~grp(0, hb)},
            {fault_n, stage.hiz, stage.switching});
        toggle_reset(1'b0);
        // thermal shutdown holds until a reset cycle
        @(posedge clk);
        detect.thermal_shutdown <= 1'b1;
        @(posedge clk);
        detect.thermal_shutdown <= 1'b0;
        settle(50);
        check_vec("thermal", 16'h00f0, {fault_n, stage.hiz, stage.switching});
        reg_read(4'h1, 8'h10);
        toggle_reset(1'b0);
        // slave mode with the sync clock stopped
        reg_write(4'h0, 8'h08);
        settle(20);
        sync_run <= 1'b0;
        settle(450);
        check_vec("stuck", 16'h001f, {fault_n, stage.hiz});
        sync_run <= 1'b1;
        wait_run();
        close_out();
    end
endmodule
bind amp_fault_top amp_fault_asserts #(.OLP_FRAMES(OLP_FRAMES)) i_amp_fault_asserts (.*);
